// >>> tts_defines.svh
// Constants for the trace and trap sequencer: status word fields, vectors, emergency stack and register file sizes.
// Assumes inclusion by bare name from the package and design files.
`ifndef TTS_DEFINES_SVH
`define TTS_DEFINES_SVH

// ----------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------
`define TTS_PSW_RESET       16'h0000
`define TTS_PSW_TRACE_BIT   4
`define TTS_PSW_REGSET_BIT  11
`define TTS_PSW_PRIO_LSB    5
`define TTS_PSW_PRIO_MSB    7

// ----------------------------------------------------------------
// Trap vectors and the emergency stack
// ----------------------------------------------------------------
`define TTS_VEC_BUS_ERR     16'h0004
`define TTS_VEC_TRACE       16'h000C
`define TTS_VEC_POWER_FAIL  16'h0014
`define TTS_EMERG_SP        16'h0004
`define TTS_EMERG_PC_ADDR   16'h0000
`define TTS_EMERG_PSW_ADDR  16'h0002

// ----------------------------------------------------------------
// Register files
// ----------------------------------------------------------------
`define TTS_GPR_COUNT       6
`define TTS_GPR_SETS        2

`endif

// >>> tts_gpr_sets.sv
// Dual general register file, selected by the status word's register-set bit.
// Assumes one clock and a synchronous active-high reset; reads are combinational.
`timescale 1ns/1ns
`include "tts_defines.svh"

module tts_gpr_sets
(
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    input  wire logic              clk_en_in,
    input  wire logic              set_sel_in,
    input  wire logic              wr_en_in,
    input  wire tts_pkg::tts_gpr_idx_t wr_idx_in,
    input  wire tts_pkg::tts_word_t    wr_data_in,
    input  wire tts_pkg::tts_gpr_idx_t rd_idx_in,
    output tts_pkg::tts_word_t     rd_data_out
);

    // ----------------------------------------------------------------
    // Storage, one bank per set
    // ----------------------------------------------------------------
    tts_pkg::tts_word_t bank_q [`TTS_GPR_SETS][`TTS_GPR_COUNT];

    genvar s;
    generate
        for (s = 0; s < `TTS_GPR_SETS; s = s + 1)
        begin : g_set
            always_ff @(posedge core_clk_in)
            begin
                if (reset_in)
                begin
                    for (int r = 0; r < `TTS_GPR_COUNT; r++)
                    begin
                        bank_q[s][r] <= 16'h0000;
                    end
                end
                else if (clk_en_in && wr_en_in && (set_sel_in == 1'(s))
                         && (int'(wr_idx_in) < `TTS_GPR_COUNT))
                begin
                    bank_q[s][wr_idx_in] <= wr_data_in;
                end
            end
        end
    endgenerate

    // Indices at or above the bank size read as zero rather than aliasing a register.
    always_comb
    begin
        if (int'(rd_idx_in) < `TTS_GPR_COUNT)
        begin
            rd_data_out = bank_q[set_sel_in][rd_idx_in];
        end
        else
        begin
            rd_data_out = 16'h0000;
        end
    end

endmodule // tts_gpr_sets

// >>> tts_intr_partner.sv
// Interrupting peripheral model: holds each request level until it is granted.
// Assumes grants show as a trap take of interrupt kind with the granted level.
`timescale 1ns/1ns

module tts_intr_partner
(
    input  wire logic                core_clk_in,
    input  wire logic                reset_in,
    input  wire logic [3:0]          raise_in,
    input  wire logic                take_in,
    input  wire tts_pkg::tts_event_e kind_in,
    input  wire logic [1:0]          ack_level_in,
    output logic [3:0]               intr_req_out,
    output tts_pkg::tts_word_t       intr_vector_out,
    output tts_pkg::tts_word_t       intr_psw_out
);
    logic [3:0] req_q;
    logic [1:0] top;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            req_q <= 4'h0;
        else if (take_in && kind_in == tts_pkg::TTS_EV_INTR)
            req_q <= (req_q | raise_in) & ~(4'h1 << ack_level_in);
        else
            req_q <= req_q | raise_in;
    end

    always_comb
    begin
        top = 2'h0;
        for (int i = 0; i < 4; i++)
            if (req_q[i])
                top = 2'(i);
    end

    // With nothing pending the vector lines show 16'hFFFF rather than a stale vector.
    assign intr_req_out    = req_q;
    assign intr_vector_out = (req_q != 4'h0) ? 16'h0100 + {12'h000, top, 2'b00} : 16'hFFFF;
    assign intr_psw_out    = {8'h00, 1'b1, top, 5'h00};
endmodule // tts_intr_partner

// >>> tts_pkg.sv
// Types shared by the trace and trap sequencer modules.
// Assumes the defines header is available on the include path.
`include "tts_defines.svh"

package tts_pkg;

    typedef enum logic [2:0]
    {
        TTS_ST_IDLE     = 3'b000,
        TTS_ST_TRACE    = 3'b001,
        TTS_ST_INTR     = 3'b010,
        TTS_ST_BUS_ERR  = 3'b011,
        TTS_ST_FATAL    = 3'b100,
        TTS_ST_PWR_FAIL = 3'b101
    } tts_state_e;

    typedef enum logic [2:0]
    {
        TTS_EV_NONE   = 3'b000,
        TTS_EV_TRACE  = 3'b001,
        TTS_EV_INTR   = 3'b010,
        TTS_EV_BUSERR = 3'b011,
        TTS_EV_FATAL  = 3'b100,
        TTS_EV_PWRF   = 3'b101
    } tts_event_e;

    typedef logic [15:0] tts_word_t;
    typedef logic [2:0]  tts_gpr_idx_t;

endpackage

// >>> tts_seq_monitor.sv
// Checker for the trace and trap sequencer, watching top-level ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`include "tts_defines.svh"

module tts_seq_monitor
(
    input wire logic                core_clk_in,
    input wire logic                reset_in,
    input wire logic                boundary_in,
    input wire logic                ret_intr_in,
    input wire logic                ret_trace_defer_in,
    input wire logic                psw_direct_wr_in,
    input wire logic                console_wr_in,
    input wire logic                reset_instr_busy_in,
    input wire tts_pkg::tts_word_t  psw_out,
    input wire logic                trap_take_out,
    input wire tts_pkg::tts_event_e trap_kind_out,
    input wire tts_pkg::tts_word_t  trap_vector_out,
    input wire logic [1:0]          intr_ack_level_out,
    input wire logic                stack_rebuild_out,
    input wire tts_pkg::tts_word_t  stack_rebuild_sp_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    // A take launched at the same edge may reload the status word, so it is excluded.
    wire logic quiet = !boundary_in && !ret_intr_in && !ret_trace_defer_in && !trap_take_out;

    pwr_hold_a: assert property
        (trap_take_out && trap_kind_out == tts_pkg::TTS_EV_PWRF |-> !$past(reset_instr_busy_in))
        else $error("power fail trap taken during reset instruction");
    trace_at_bnd_a: assert property
        (trap_take_out && trap_kind_out == tts_pkg::TTS_EV_TRACE |-> $past(boundary_in))
        else $error("trace trap taken away from a boundary");
    trace_vec_a: assert property
        (trap_take_out && trap_kind_out == tts_pkg::TTS_EV_TRACE |-> trap_vector_out == 16'h000C)
        else $error("trace trap vector wrong");
    take_pulse_a: assert property
        (trap_take_out |=> !trap_take_out)
        else $error("trap take held longer than one cycle");
    direct_keep_a: assert property
        (psw_direct_wr_in && quiet && !$past(boundary_in) |=> psw_out[4] == $past(psw_out[4]))
        else $error("direct status write changed trace bit");
    console_keep_a: assert property
        (console_wr_in && quiet && !$past(boundary_in) |=> psw_out[4] == $past(psw_out[4]))
        else $error("console write changed trace bit");
    rebuild_sp_a: assert property
        (stack_rebuild_out |-> stack_rebuild_sp_out == `TTS_EMERG_SP)
        else $error("fresh stack pointer wrong");
    intr_prio_a: assert property
        (trap_take_out && trap_kind_out == tts_pkg::TTS_EV_INTR
            |-> 3'd4 + {1'b0, intr_ack_level_out} > $past(psw_out[7:5]))
        else $error("interrupt granted at or below status priority");

    trace_c: cover property (trap_take_out && trap_kind_out == tts_pkg::TTS_EV_TRACE);
    intr_c: cover property (trap_take_out && trap_kind_out == tts_pkg::TTS_EV_INTR);
    rebuild_c: cover property (stack_rebuild_out);
endmodule // tts_seq_monitor

bind tts_trace_trap_sequencer tts_seq_monitor u_mon
(
    .core_clk_in(core_clk_in), .reset_in(reset_in), .boundary_in(boundary_in),
    .ret_intr_in(ret_intr_in), .ret_trace_defer_in(ret_trace_defer_in),
    .psw_direct_wr_in(psw_direct_wr_in), .console_wr_in(console_wr_in),
    .reset_instr_busy_in(reset_instr_busy_in), .psw_out(psw_out),
    .trap_take_out(trap_take_out), .trap_kind_out(trap_kind_out),
    .trap_vector_out(trap_vector_out), .intr_ack_level_out(intr_ack_level_out),
    .stack_rebuild_out(stack_rebuild_out), .stack_rebuild_sp_out(stack_rebuild_sp_out)
);

// >>> tts_trace_trap_sequencer.sv
// Trace and trap sequencer: chooses the next trap or interrupt at each instruction boundary.
// Assumes the instruction engine reports boundaries and events on core_clk_in; the
// interrupt request and power-fail lines come from the bus and are synchronised here.
`timescale 1ns/1ns
`include "tts_defines.svh"

module tts_trace_trap_sequencer
(
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  clk_en_in,
    input  wire logic                  boundary_in,
    input  wire logic                  ret_intr_in,
    input  wire logic                  ret_trace_defer_in,
    input  wire tts_pkg::tts_word_t    ret_psw_in,
    input  wire logic                  psw_direct_wr_in,
    input  wire logic                  console_wr_in,
    input  wire tts_pkg::tts_word_t    psw_wr_data_in,
    input  wire logic                  reset_instr_busy_in,
    input  wire logic                  power_fail_in,
    input  wire logic [3:0]            intr_req_in,
    input  wire tts_pkg::tts_word_t    intr_vector_in,
    input  wire tts_pkg::tts_word_t    intr_psw_in,
    input  wire logic                  bus_err_in,
    input  wire logic                  bus_err_sp_in,
    input  wire logic                  gpr_wr_en_in,
    input  wire tts_pkg::tts_gpr_idx_t gpr_wr_idx_in,
    input  wire tts_pkg::tts_word_t    gpr_wr_data_in,
    input  wire tts_pkg::tts_gpr_idx_t gpr_rd_idx_in,
    output tts_pkg::tts_word_t         gpr_rd_data_out,
    output tts_pkg::tts_word_t         psw_out,
    output logic                       trap_take_out,
    output tts_pkg::tts_event_e        trap_kind_out,
    output tts_pkg::tts_word_t         trap_vector_out,
    output logic [1:0]                 intr_ack_level_out,
    output logic                       stack_rebuild_out,
    output tts_pkg::tts_word_t         stack_rebuild_sp_out
);

    // ----------------------------------------------------------------
    // Input synchronisers for bus-side levels
    // ----------------------------------------------------------------
    logic [3:0] irq_meta_q;
    logic [3:0] irq_q;
    logic       pwr_meta_q;
    logic       pwr_q;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            irq_meta_q <= 4'h0;
            irq_q      <= 4'h0;
            pwr_meta_q <= 1'b0;
            pwr_q      <= 1'b0;
        end
        else if (clk_en_in)
        begin
            irq_meta_q <= intr_req_in;
            irq_q      <= irq_meta_q;
            pwr_meta_q <= power_fail_in;
            pwr_q      <= pwr_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Pending state
    // ----------------------------------------------------------------
    tts_pkg::tts_word_t psw_q;
    logic               trace_now_q;
    logic               trace_defer_q;
    logic               pwr_pend_q;
    logic               in_trap_q;
    logic               fatal_pend_q;
    logic               buserr_pend_q;
    tts_pkg::tts_state_e state_q;

    logic       trace_bit;
    logic [2:0] cur_prio;
    logic       irq_any;
    logic [1:0] irq_lvl;
    logic [2:0] irq_prio;
    logic       irq_win;
    logic       pwr_ok;
    logic       pwr_prev_q;

    logic                trap_take_d;
    tts_pkg::tts_event_e kind_d;
    tts_pkg::tts_word_t  vec_d;
    tts_pkg::tts_word_t  entry_psw;
    logic                trace_due;

    assign trace_bit = psw_q[`TTS_PSW_TRACE_BIT];
    assign cur_prio  = psw_q[`TTS_PSW_PRIO_MSB:`TTS_PSW_PRIO_LSB];
    assign pwr_ok    = pwr_pend_q && !reset_instr_busy_in;

    // Four request levels map onto processor priorities 4 to 7.
    always_comb
    begin
        irq_any = |irq_q;
        irq_lvl = 2'd0;
        for (int i = 0; i < 4; i++)
        begin
            if (irq_q[i])
            begin
                irq_lvl = 2'(i);
            end
        end
        irq_prio = {1'b1, irq_lvl};
        irq_win  = irq_any && (irq_prio > cur_prio);
    end

    // Power fail is caught on its rising edge, so a fail line that stays asserted traps once.
    // The pending flag clears only when that trap is really taken, and a new edge wins.
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            pwr_prev_q <= 1'b0;
            pwr_pend_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pwr_prev_q <= pwr_q;
            if (pwr_q && !pwr_prev_q)
            begin
                pwr_pend_q <= 1'b1;
            end
            else if (boundary_in && state_q == tts_pkg::TTS_ST_IDLE
                     && kind_d == tts_pkg::TTS_EV_PWRF)
            begin
                pwr_pend_q <= 1'b0;
            end
        end
    end

    // Bus errors are classified when they happen and consumed at the next boundary, a plain one only once no fatal one is pending.
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            fatal_pend_q  <= 1'b0;
            buserr_pend_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (bus_err_in && (bus_err_sp_in || in_trap_q))
            begin
                fatal_pend_q <= 1'b1;
            end
            else if (boundary_in && fatal_pend_q)
            begin
                fatal_pend_q <= 1'b0;
            end
            if (bus_err_in && !bus_err_sp_in && !in_trap_q)
            begin
                buserr_pend_q <= 1'b1;
            end
            else if (boundary_in && buserr_pend_q && !fatal_pend_q)
            begin
                buserr_pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status word and trace bookkeeping
    // ----------------------------------------------------------------
    // The trace bit is kept from direct and console writes, so software can never
    // single-step itself without going through a return or a trap.
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            psw_q         <= `TTS_PSW_RESET;
            trace_now_q   <= 1'b0;
            trace_defer_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (ret_intr_in || ret_trace_defer_in)
            begin
                psw_q         <= ret_psw_in;
                trace_now_q   <= ret_intr_in && ret_psw_in[`TTS_PSW_TRACE_BIT];
                trace_defer_q <= ret_trace_defer_in && ret_psw_in[`TTS_PSW_TRACE_BIT];
            end
            else if (boundary_in && state_q == tts_pkg::TTS_ST_IDLE && trap_take_d)
            begin
                psw_q       <= entry_psw;
                trace_now_q <= 1'b0;
            end
            else if (psw_direct_wr_in || console_wr_in)
            begin
                psw_q <= {psw_wr_data_in[15:`TTS_PSW_TRACE_BIT + 1], trace_bit,
                          psw_wr_data_in[`TTS_PSW_TRACE_BIT - 1:0]};
            end
            else if (boundary_in)
            begin
                // The deferred trace arms once the following instruction has finished.
                trace_now_q   <= trace_now_q | (trace_defer_q & trace_bit);
                trace_defer_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Boundary arbitration
    // ----------------------------------------------------------------
    assign trace_due = trace_now_q || (trace_bit && !trace_defer_q && !ret_intr_in);

    always_comb
    begin
        trap_take_d = 1'b1;
        kind_d      = tts_pkg::TTS_EV_NONE;
        vec_d       = 16'h0000;
        entry_psw   = psw_q;
        if (fatal_pend_q)
        begin
            kind_d = tts_pkg::TTS_EV_FATAL;
            vec_d  = `TTS_VEC_BUS_ERR;
        end
        else if (buserr_pend_q)
        begin
            kind_d = tts_pkg::TTS_EV_BUSERR;
            vec_d  = `TTS_VEC_BUS_ERR;
        end
        else if (pwr_ok)
        begin
            kind_d = tts_pkg::TTS_EV_PWRF;
            vec_d  = `TTS_VEC_POWER_FAIL;
        end
        else if (trace_due && !trace_defer_q)
        begin
            kind_d = tts_pkg::TTS_EV_TRACE;
            vec_d  = `TTS_VEC_TRACE;
        end
        else if (irq_win)
        begin
            // Checked at every boundary, including the one before a new routine's first
            // instruction, so a higher request pre-empts it.
            kind_d    = tts_pkg::TTS_EV_INTR;
            vec_d     = intr_vector_in;
            entry_psw = intr_psw_in;
        end
        else
        begin
            trap_take_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_q              <= tts_pkg::TTS_ST_IDLE;
            in_trap_q            <= 1'b0;
            trap_take_out        <= 1'b0;
            trap_kind_out        <= tts_pkg::TTS_EV_NONE;
            trap_vector_out      <= 16'h0000;
            intr_ack_level_out   <= 2'd0;
            stack_rebuild_out    <= 1'b0;
            stack_rebuild_sp_out <= 16'h0000;
        end
        else if (clk_en_in)
        begin
            trap_take_out     <= 1'b0;
            stack_rebuild_out <= 1'b0;
            case (state_q)
                tts_pkg::TTS_ST_IDLE:
                begin
                    if (boundary_in && trap_take_d)
                    begin
                        trap_take_out   <= 1'b1;
                        trap_kind_out   <= kind_d;
                        trap_vector_out <= vec_d;
                        in_trap_q       <= 1'b1;
                        if (kind_d == tts_pkg::TTS_EV_INTR)
                        begin
                            intr_ack_level_out <= irq_lvl;
                        end
                        if (kind_d == tts_pkg::TTS_EV_FATAL && in_trap_q)
                        begin
                            stack_rebuild_out    <= 1'b1;
                            stack_rebuild_sp_out <= `TTS_EMERG_SP;
                        end
                        state_q <= (kind_d == tts_pkg::TTS_EV_FATAL)
                                   ? tts_pkg::TTS_ST_FATAL : tts_pkg::TTS_ST_TRACE;
                    end
                    else if (boundary_in)
                    begin
                        in_trap_q <= 1'b0;
                    end
                end
                tts_pkg::TTS_ST_TRACE, tts_pkg::TTS_ST_FATAL:
                begin
                    // One idle cycle lets the engine start the vector fetch.
                    state_q <= tts_pkg::TTS_ST_IDLE;
                end
                default:
                begin
                    state_q <= tts_pkg::TTS_ST_IDLE;
                end
            endcase
        end
    end

    assign psw_out = psw_q;

    // ----------------------------------------------------------------
    // Register sets
    // ----------------------------------------------------------------
    tts_gpr_sets u_gpr
    (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .clk_en_in   (clk_en_in),
        .set_sel_in  (psw_q[`TTS_PSW_REGSET_BIT]),
        .wr_en_in    (gpr_wr_en_in),
        .wr_idx_in   (gpr_wr_idx_in),
        .wr_data_in  (gpr_wr_data_in),
        .rd_idx_in   (gpr_rd_idx_in),
        .rd_data_out (gpr_rd_data_out)
    );

endmodule // tts_trace_trap_sequencer

// >>> tts_trace_trap_sequencer_tb.sv
// Self-checking bench for the trace and trap sequencer with an interrupt partner.
// Assumes the package, design, partner and checker files are compiled before it.
`timescale 1ns/1ns
`include "tts_defines.svh"

module tts_trace_trap_sequencer_tb;
    logic                clk = 1'b0, rst = 1'b1, bnd = 1'b0, return_from_interrupt = 1'b0, return_with_trace_deferral = 1'b0;
    logic                dwr = 1'b0, cwr = 1'b0, busy = 1'b0, pf = 1'b0, be = 1'b0;
    logic                bsp = 1'b0, gwe = 1'b0, take, rbld, seen_rb;
    logic [3:0]          raise = 4'h0, req;
    logic [1:0]          alv;
    tts_pkg::tts_word_t  rpsw = 16'h0000, wdat = 16'h0000, gdat = 16'h0000;
    tts_pkg::tts_word_t  ivec, ipsw, grd, psw, tvec, rsp;
    tts_pkg::tts_gpr_idx_t gwi = 3'h0, gri = 3'h0;
    tts_pkg::tts_event_e kind;
    int                  n_mismatch = 0, cmp_count = 0, m_tr = 0, m_pend = 0, m_prio = 0;
    int                  m_trap = 0, gm [2][6];
    logic [31:0]         rs = 32'h0000005C;

    always #5 clk = ~clk;
    always @(posedge clk) if (rbld === 1'b1) seen_rb = 1'b1;

    tts_trace_trap_sequencer uut
    (
        .core_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .boundary_in(bnd),
        .ret_intr_in(return_from_interrupt), .ret_trace_defer_in(return_with_trace_deferral), .ret_psw_in(rpsw),
        .psw_direct_wr_in(dwr), .console_wr_in(cwr), .psw_wr_data_in(wdat),
        .reset_instr_busy_in(busy), .power_fail_in(pf), .intr_req_in(req),
        .intr_vector_in(ivec), .intr_psw_in(ipsw), .bus_err_in(be), .bus_err_sp_in(bsp),
        .gpr_wr_en_in(gwe), .gpr_wr_idx_in(gwi), .gpr_wr_data_in(gdat), .gpr_rd_idx_in(gri),
        .gpr_rd_data_out(grd), .psw_out(psw), .trap_take_out(take), .trap_kind_out(kind),
        .trap_vector_out(tvec), .intr_ack_level_out(alv), .stack_rebuild_out(rbld),
        .stack_rebuild_sp_out(rsp)
    );

    tts_intr_partner u_dev
    (
        .core_clk_in(clk), .reset_in(rst), .raise_in(raise), .take_in(take), .kind_in(kind),
        .ack_level_in(alv), .intr_req_out(req), .intr_vector_out(ivec), .intr_psw_out(ipsw)
    );

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic ret(input logic d, input tts_pkg::tts_word_t p);
        @(posedge clk);
        return_from_interrupt  <= !d;
        return_with_trace_deferral  <= d;
        rpsw <= p;
        @(posedge clk);
        return_from_interrupt  <= 1'b0;
        return_with_trace_deferral  <= 1'b0;
        m_tr = p[4] ? (d ? 2 : 1) : 0;
        m_prio = p[7:5];
    endtask

    task automatic raise_req(input logic [3:0] m);
        @(posedge clk);
        raise <= m;
        @(posedge clk);
        raise <= 4'h0;
        m_pend = m_pend | m;
        repeat (4) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // Boundary with the reference model of arbitration
    // ----------------------------------------------------------------
    task automatic bstep(input logic e, input logic sp);
        int ek;
        int lv;
        tts_pkg::tts_word_t ev;
        seen_rb = 1'b0;
        @(posedge clk);
        be  <= e;
        bsp <= sp;
        // The model reads pf and busy only once they have settled after the caller's edge.
        ek = 0;
        lv = 0;
        for (int i = 0; i < 4; i++)
            if (m_pend[i] && 4 + i > m_prio)
                lv = i + 1;
        if (e)
            ek = (sp || m_trap != 0) ? 4 : 3;
        else if (pf && !busy)
            ek = 5;
        else if (m_tr == 1)
            ek = 1;
        else if (lv > 0)
            ek = 2;
        ev = ek == 1 ? `TTS_VEC_TRACE : ek == 3 ? `TTS_VEC_BUS_ERR :
             ek == 5 ? `TTS_VEC_POWER_FAIL : 16'h0100 + 16'(4 * lv - 4);
        @(posedge clk);
        be  <= 1'b0;
        bnd <= 1'b1;
        @(posedge clk);
        bnd <= 1'b0;
        #1;
        chk("take", 16'(ek != 0), 16'(take));
        if (ek != 0)
            chk("kind", 16'(ek), 16'(kind));
        if (ek != 0 && ek != 4)
            chk("vector", ev, tvec);
        repeat (2) @(posedge clk);
        #1;
        chk("rebuild", 16'(e && m_trap != 0), 16'(seen_rb));
        if (m_tr == 2)
            m_tr = 1;
        if (ek == 1)
            m_tr = 0;
        if (ek == 2)
        begin
            m_pend[lv - 1] = 1'b0;
            m_prio = 3 + lv;
        end
        m_trap = ek != 0;
    endtask

    task automatic pswr(input logic con, input tts_pkg::tts_word_t d);
        tts_pkg::tts_word_t old;
        @(posedge clk);
        old  = psw;
        dwr  <= !con;
        cwr  <= con;
        wdat <= d;
        @(posedge clk);
        dwr  <= 1'b0;
        cwr  <= 1'b0;
        @(posedge clk);
        #1;
        chk("psw", (d & 16'hFFEF) | (old & 16'h0010), psw);
        m_prio = d[7:5];
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        ret(1'b0, 16'h0010);
        bstep(1'b0, 1'b0);
        ret(1'b1, 16'h0010);
        bstep(1'b0, 1'b0);
        bstep(1'b0, 1'b0);
        ret(1'b0, 16'h0000);
        $display("test trace returns done");
        ret(1'b0, 16'h0010);
        raise_req(4'h1);
        bstep(1'b0, 1'b0);
        ret(1'b0, 16'h0000);
        bstep(1'b0, 1'b0);
        raise_req(4'h6);
        bstep(1'b0, 1'b0);
        bstep(1'b0, 1'b0);
        ret(1'b0, 16'h0000);
        bstep(1'b0, 1'b0);
        ret(1'b0, 16'h0000);
        $display("test interrupts done");
        busy <= 1'b1;
        pf   <= 1'b1;
        bstep(1'b0, 1'b0);
        @(posedge clk);
        busy <= 1'b0;
        bstep(1'b0, 1'b0);
        @(posedge clk);
        pf   <= 1'b0;
        repeat (4) @(posedge clk);
        ret(1'b0, 16'h0000);
        $display("test power fail done");
        bstep(1'b0, 1'b0);
        bstep(1'b1, 1'b1);
        bstep(1'b1, 1'b0);
        ret(1'b0, 16'h0000);
        bstep(1'b0, 1'b0);
        bstep(1'b1, 1'b0);
        ret(1'b0, 16'h0000);
        $display("test bus errors done");
        for (int c = 0; c < 2; c++)
        begin
            pswr(1'(c), xs() | 16'h0010);
            ret(1'b0, 16'h0010);
            pswr(1'(c), 16'h0000);
            ret(1'b0, 16'h0000);
        end
        $display("test status writes done");
        for (int s = 0; s < 2; s++)
        begin
            pswr(1'b0, s ? 16'h0800 : 16'h0000);
            for (int i = 0; i < 6; i++)
            begin
                gm[s][i] = xs() & 16'hFFFF;
                @(posedge clk);
                gwe  <= 1'b1;
                gwi  <= 3'(i);
                gdat <= 16'(gm[s][i]);
                @(posedge clk);
                gwe  <= 1'b0;
            end
        end
        for (int s = 0; s < 2; s++)
        begin
            pswr(1'b0, s ? 16'h0800 : 16'h0000);
            for (int i = 0; i < 6; i++)
            begin
                @(posedge clk);
                gri <= 3'(i);
                #1;
                chk("gpr", 16'(gm[s][i]), grd);
            end
        end
        $display("test register sets done");
        wrap_up();
    end
endmodule // tts_trace_trap_sequencer_tb
